//--- design/lms_list_sequencer.v
/*
 * List mode sequencer: steps through frequency/level entries with dwell,
 * auto, single and step processing, trigger edges, index range.
 * Assumes list entries written by software over the write port, an
 * asynchronous trigger pin, and a settle flag from the synthesiser.
 */
`include "lms_defines.vh"
`default_nettype none

// Functional notes
// - Turning list on starts output from the selected list in auto mode; single and step modes wait first.
// - Sweep enable turns list off; list enable requests sweeps off.
// - Index writable in step mode only; otherwise shows current entry.
// - Auto mode walks entries on dwell expiry; entering auto restarts top.
// - Single mode: each trigger runs one pass start to stop.
// - After a single pass, hold and wait for next trigger.
// - Step mode ignores dwell expiry; each advance needs a trigger.
// - Global dwell selection holds every entry for one value.
// - Per-entry dwell selection uses each entry's stored dwell.
// - Substantial dwell overrun switches list processing off.
// - Polarity setting picks active external trigger edge.
// - Rising edge triggers if positive, falling if negative.
// - Reset command returns to the starting entry.
// - Software execute starts one single pass like a trigger; the code takes exec_cmd as the trigger only while ext_trig_sel is low.
// - Programmable start and stop indices bound processing.
// - Only entries inside start-to-stop range are output, except an index written in step mode.
module lms_list_sequencer (
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    // Control
    input wire list_en,
    input wire sweep_en,
    input wire [1:0] mode,
    input wire ext_trig_sel,
    input wire dwell_sel,
    input wire trig_slope,
    input wire [`LMS_DWELL_W-1:0] global_dwell,
    input wire [`LMS_IDX_W-1:0] range_start,
    input wire [`LMS_IDX_W-1:0] range_stop,
    input wire reset_cmd,
    input wire exec_cmd,
    input wire index_wr,
    input wire [`LMS_IDX_W-1:0] index_wdata,
    // List memory write
    input wire mem_wr,
    input wire [`LMS_IDX_W-1:0] mem_addr,
    input wire [`LMS_FREQ_W-1:0] mem_freq,
    input wire [`LMS_LVL_W-1:0] mem_lvl,
    input wire [`LMS_DWELL_W-1:0] mem_dwell,
    // External trigger pin
    input wire ext_trig,
    // Synthesiser settle
    input wire rf_settled,
    // Outputs
    output reg [`LMS_FREQ_W-1:0] freq_out,
    output reg [`LMS_LVL_W-1:0] lvl_out,
    output reg out_valid,
    output wire [`LMS_IDX_W-1:0] cur_index,
    output reg list_active,
    output reg sweep_off_req,
    output reg overrun_off,
    output reg pass_done
);

localparam ST_IDLE = 2'h0;
localparam ST_LOAD = 2'h1;
localparam ST_DWELL = 2'h2;
localparam ST_WAIT = 2'h3;

reg [`LMS_FREQ_W-1:0] freq_mem [0:`LMS_DEPTH-1];
reg [`LMS_LVL_W-1:0] lvl_mem [0:`LMS_DEPTH-1];
reg [`LMS_DWELL_W-1:0] dwell_mem [0:`LMS_DEPTH-1];

reg [1:0] state_reg;
reg [`LMS_IDX_W-1:0] idx_reg;
reg [`LMS_DWELL_W-1:0] dwell_cnt_reg;
reg [`LMS_TICK_W-1:0] tick_cnt_reg;
reg [1:0] mode_reg;
reg trig_s1_reg;
reg trig_s2_reg;
reg trig_s3_reg;
reg [3:0] ovr_cnt_reg;
reg en_reg;
reg list_en_prev_reg;

wire list_on;
wire tick;
wire dwell_done;
wire trig_rise;
wire trig_fall;
wire trig_edge;
wire trig_evt;
wire [`LMS_IDX_W-1:0] idx_next;
wire [`LMS_DWELL_W-1:0] dwell_val;
wire at_stop;

// Next index within range, wrapping stop to start
function [`LMS_IDX_W-1:0] lms_next_idx;
    input [`LMS_IDX_W-1:0] cur;
    input [`LMS_IDX_W-1:0] lo;
    input [`LMS_IDX_W-1:0] hi;
    begin
        if (cur >= hi || cur < lo) begin
            lms_next_idx = lo;
        end else begin
            lms_next_idx = cur + 1'b1;
        end
    end
endfunction

// Last dwell unit of the current entry has elapsed
function lms_dwell_done;
    input tk;
    input [`LMS_DWELL_W-1:0] cnt;
    begin
        lms_dwell_done = tk && (cnt <= 1);
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// List memory
always @(posedge clk_sys) begin
    if (mem_wr) begin
        freq_mem[mem_addr] <= mem_freq;
        lvl_mem[mem_addr] <= mem_lvl;
        dwell_mem[mem_addr] <= mem_dwell;
    end
end

////////////////////////////////////////////////////////////////////////////
// Trigger pin synchroniser and edge detection
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        trig_s1_reg <= 1'b0;
        trig_s2_reg <= 1'b0;
        trig_s3_reg <= 1'b0;
    end else begin
        trig_s1_reg <= ext_trig;
        trig_s2_reg <= trig_s1_reg;
        trig_s3_reg <= trig_s2_reg;
    end
end

assign trig_rise = trig_s2_reg & ~trig_s3_reg;
assign trig_fall = ~trig_s2_reg & trig_s3_reg;
assign trig_edge = (trig_slope == `LMS_SLOPE_POS) ? trig_rise : trig_fall;
assign trig_evt = ext_trig_sel ? trig_edge : exec_cmd;

////////////////////////////////////////////////////////////////////////////
// Dwell unit tick divider
assign tick = (tick_cnt_reg == `LMS_TICK_CYC - 1);

always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        tick_cnt_reg <= {`LMS_TICK_W{1'b0}};
    end else if (tick || state_reg != ST_DWELL) begin
        tick_cnt_reg <= {`LMS_TICK_W{1'b0}};
    end else begin
        tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////
// Enable edge tracking
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        list_en_prev_reg <= 1'b0;
    end else begin
        list_en_prev_reg <= list_en;
    end
end

////////////////////////////////////////////////////////////////////////////
// Sequencing
// sweep enable overrides list
assign list_on = en_reg & ~sweep_en;
assign at_stop = (idx_reg == range_stop);
assign idx_next = lms_next_idx(idx_reg, range_start, range_stop);
assign dwell_done = lms_dwell_done(tick, dwell_cnt_reg);
assign dwell_val = (dwell_sel == `LMS_DWELL_GLOBAL) ? global_dwell :
    dwell_mem[idx_reg];
assign cur_index = idx_reg;

always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        state_reg <= ST_IDLE;
        idx_reg <= {`LMS_IDX_W{1'b0}};
        dwell_cnt_reg <= {`LMS_DWELL_W{1'b0}};
        mode_reg <= `LMS_MODE_AUTO;
        ovr_cnt_reg <= 4'h0;
        en_reg <= 1'b0;
        freq_out <= {`LMS_FREQ_W{1'b0}};
        lvl_out <= {`LMS_LVL_W{1'b0}};
        out_valid <= 1'b0;
        list_active <= 1'b0;
        sweep_off_req <= 1'b0;
        overrun_off <= 1'b0;
        pass_done <= 1'b0;
    end else begin
        pass_done <= 1'b0;
        sweep_off_req <= 1'b0;
        mode_reg <= mode;
        // Rising list_en only, so an overrun shutdown sticks
        if (list_en && !list_en_prev_reg) begin
            en_reg <= 1'b1;
            overrun_off <= 1'b0;
            sweep_off_req <= 1'b1;
        end else if (!list_en) begin
            en_reg <= 1'b0;
        end
        list_active <= list_on;
        if (!list_on) begin
            state_reg <= ST_IDLE;
            out_valid <= 1'b0;
            ovr_cnt_reg <= 4'h0;
        end else if (reset_cmd ||
            (mode == `LMS_MODE_AUTO && mode_reg != `LMS_MODE_AUTO)) begin
            idx_reg <= range_start;
            state_reg <= (mode == `LMS_MODE_AUTO) ? ST_LOAD : ST_WAIT;
        end else begin
            case (state_reg)
            ST_IDLE: begin
                idx_reg <= range_start;
                state_reg <= (mode == `LMS_MODE_AUTO) ? ST_LOAD : ST_WAIT;
            end
            ST_LOAD: begin
                freq_out <= freq_mem[idx_reg];
                lvl_out <= lvl_mem[idx_reg];
                out_valid <= 1'b1;
                dwell_cnt_reg <= dwell_val;
                state_reg <= ST_DWELL;
            end
            ST_DWELL: begin
                // count overruns, shut off if substantial
                if (!rf_settled && dwell_done) begin
                    if (ovr_cnt_reg == `LMS_OVR_LIMIT - 1) begin
                        en_reg <= 1'b0;
                        overrun_off <= 1'b1;
                    end
                    ovr_cnt_reg <= ovr_cnt_reg + 1'b1;
                end else if (dwell_done) begin
                    ovr_cnt_reg <= 4'h0;
                end
                if (mode == `LMS_MODE_STEP) begin
                    // no advance on dwell in step mode
                    state_reg <= ST_WAIT;
                end else if (tick) begin
                    if (dwell_cnt_reg > 1) begin
                        dwell_cnt_reg <= dwell_cnt_reg - 1'b1;
                    end else if (at_stop && mode == `LMS_MODE_SINGLE) begin
                        pass_done <= 1'b1;
                        state_reg <= ST_WAIT;
                    end else begin
                        idx_reg <= idx_next;
                        state_reg <= ST_LOAD;
                    end
                end
            end
            ST_WAIT: begin
                if (mode == `LMS_MODE_STEP) begin
                    if (index_wr) begin
                        idx_reg <= index_wdata;
                        state_reg <= ST_LOAD;
                    end else if (trig_evt) begin
                        idx_reg <= (out_valid) ? idx_next : range_start;
                        state_reg <= ST_LOAD;
                    end
                end else if (mode == `LMS_MODE_SINGLE) begin
                    if (trig_evt) begin
                        idx_reg <= range_start;
                        state_reg <= ST_LOAD;
                    end
                end else begin
                    state_reg <= ST_LOAD;
                end
            end
            default: state_reg <= ST_IDLE;
            endcase
        end
    end
end

endmodule // lms_list_sequencer

`default_nettype wire

//--- design/lms_defines.vh
/*
 * Constants for the list mode sequencer: widths, mode codes, dwell timing.
 * Assumes inclusion by bare name from the sequencer source.
 */
`ifndef LMS_DEFINES_VH
`define LMS_DEFINES_VH

`define LMS_IDX_W 10
`define LMS_DEPTH 1024
`define LMS_FREQ_W 48
`define LMS_LVL_W 16
`define LMS_DWELL_W 24

`define LMS_MODE_AUTO 2'h0
`define LMS_MODE_SINGLE 2'h1
`define LMS_MODE_STEP 2'h2

`define LMS_DWELL_GLOBAL 1'b0
`define LMS_DWELL_LIST 1'b1

`define LMS_SLOPE_POS 1'b0
`define LMS_SLOPE_NEG 1'b1

// Dwell unit of 1 us at 10 MHz clock
`define LMS_CLK_HZ 10000000
`define LMS_DWELL_UNIT_NS 1000
`define LMS_TICK_CYC ((`LMS_DWELL_UNIT_NS * (`LMS_CLK_HZ / 1000000)) / 1000)
`define LMS_TICK_W 8

// Default global dwell 10000 us
`define LMS_GDWELL_RST 24'h002710
// Overrun events in a row that shut the list off
`define LMS_OVR_LIMIT 4'h4

`endif

//--- verification/lms_trig_src.sv
/* External trigger source model for the list sequencer trigger pin.
   Assumes the bench raises fire for one clock per wanted trigger. */
`default_nettype none
module lms_trig_src (
    // Clock and commands
    input wire logic clk_sys,
    input wire logic fire,
    input wire logic neg,
    // Trigger pin
    output logic ext_trig
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] hold_reg = 3'h0;
    always @(posedge clk_sys) begin
        if (fire)
            hold_reg <= 3'h5;
        else if (hold_reg != 3'h0)
            hold_reg <= hold_reg - 3'h1;
    end
    assign ext_trig = neg ^ (hold_reg != 3'h0);
endmodule // lms_trig_src
`default_nettype wire

//--- verification/lms_seq_chk_chk.sv
/* Port checker for the list sequencer.
   Assumes one clock domain and a bind onto the sequencer. */
`include "lms_defines.vh"
`default_nettype none
module lms_seq_chk (
    // Clock, reset, controls
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic list_en,
    input wire logic sweep_en,
    input wire logic [1:0] mode,
    input wire logic [9:0] range_start,
    input wire logic [9:0] range_stop,
    // Watched outputs
    input wire logic [9:0] cur_index,
    input wire logic list_active,
    input wire logic sweep_off_req,
    input wire logic overrun_off,
    input wire logic pass_done
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_sweep_kills_list: assert property (
        sweep_en |=> !list_active) else $error("list on under sweep");
    a_enable_req_pulse: assert property (
        $rose(list_en) |=> sweep_off_req) else $error("no sweep off");
    a_req_one_cycle: assert property (
        sweep_off_req |=> !sweep_off_req) else $error("long sweep off");
    a_idle_when_off: assert property (
        !list_en |=> ##1 !list_active) else $error("active while off");
    a_on_follows_en: assert property (
        ($rose(list_en) && !sweep_en) ##1 !sweep_en |=> list_active)
        else $error("list not started");
    a_index_in_range: assert property (
        list_active && $changed(cur_index) |->
        cur_index >= range_start && cur_index <= range_stop)
        else $error("index outside range");
    a_auto_dwell_min: assert property (
        list_active && mode == `LMS_MODE_AUTO && $changed(cur_index)
        |=> $stable(cur_index) [*8]) else $error("dwell too short");
    a_pass_at_stop: assert property (
        pass_done |-> cur_index == range_stop ##1 !pass_done)
        else $error("pass end wrong");
    a_overrun_stops: assert property (
        $rose(overrun_off) |=> !list_active [*2])
        else $error("list on after overrun");
endmodule // lms_seq_chk
bind lms_list_sequencer lms_seq_chk i_chk (.*);
`default_nettype wire

//--- verification/tb.sv
/* Bench for the list sequencer: auto, step, single and overrun runs.
   Assumes the design header is on the include path. */
`include "lms_defines.vh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 0, rst_n = 0, list_en = 0, sweep_en = 0;
    logic [1:0] mode = 0;
    logic ext_trig_sel = 0, dwell_sel = 0, trig_slope = 0, neg = 0;
    logic [23:0] global_dwell = 2, mem_dwell = 0;
    logic [9:0] range_start = 0, range_stop = 0, index_wdata = 0;
    logic [9:0] mem_addr = 0, last_idx = 0;
    logic reset_cmd = 0, exec_cmd = 0, index_wr = 0, mem_wr = 0;
    logic [47:0] mem_freq = 0;
    logic [15:0] mem_lvl = 0;
    logic [47:0] ref_freq [8];
    logic [15:0] ref_lvl [8];
    logic rf_settled = 1, fire = 0, watch = 0, ext_trig;
    wire [47:0] freq_out;
    wire [15:0] lvl_out;
    wire [9:0] cur_index;
    wire out_valid, list_active, sweep_off_req, overrun_off, pass_done;
    int bad_count = 0, total_checks = 0, seed = 18;
    logic [9:0] exp_q[$];
    lms_list_sequencer i_dut (.*);
    lms_trig_src i_src (.*);
    always #50 clk_sys = ~clk_sys;
    task automatic check(input logic [47:0] seen, input logic [47:0] want);
        total_checks++;
        if (seen !== want) begin
            bad_count++;
            $display("wrong value at %0t: %h vs %h", $time, seen, want);
        end
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        tick(1);
        s = 0;
    endtask
    task automatic drain(input int n);
        while (exp_q.size() != 0 && n > 0) begin
            tick(1);
            n--;
        end
        if (exp_q.size() != 0) begin
            bad_count++;
            final_report;
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    always @(negedge clk_sys) begin
        if (watch && cur_index !== last_idx)
            check(cur_index, exp_q.size() ? exp_q.pop_front() : last_idx);
        last_idx = cur_index;
    end
    initial begin
        int n;
        tick(12);
        rst_n = 1;
        mem_wr = 1;
        for (int a = 0; a < 8; a++) begin
            mem_addr = a[9:0];
            mem_freq = {16'h0, $random(seed)};
            mem_lvl = 16'($random(seed));
            mem_dwell = 24'(1 + ($random(seed) & 3));
            ref_freq[a] = mem_freq;
            ref_lvl[a] = mem_lvl;
            tick(1);
        end
        mem_wr = 0;
        range_start = 2;
        range_stop = 4;
        exp_q = '{10'h2, 10'h3, 10'h4, 10'h2, 10'h3};
        watch = 1;
        list_en = 1;
        drain(400);
        watch = 0;
        tick(30);
        sweep_en = 1;
        tick(2);
        check(list_active, 1'b0);
        check(out_valid, 1'b0);
        list_en = 0;
        sweep_en = 0;
        mode = `LMS_MODE_STEP;
        ext_trig_sel = 1;
        range_start = 1;
        range_stop = 3;
        tick(2);
        list_en = 1;
        tick(3);
        index_wdata = 10'h3;
        pulse(index_wr);
        tick(2);
        check(cur_index, 10'h3);
        check(freq_out, ref_freq[3]);
        check(lvl_out, ref_lvl[3]);
        check(out_valid, 1'b1);
        pulse(reset_cmd);
        tick(2);
        check(cur_index, 10'h1);
        exp_q = '{10'h2, 10'h3, 10'h1};
        watch = 1;
        for (int t = 0; t < 3; t++) begin
            if (t == 2) begin
                trig_slope = `LMS_SLOPE_NEG;
                neg = 1;
                tick(8);
            end
            pulse(fire);
            tick(12);
        end
        drain(20);
        watch = 0;
        list_en = 0;
        mode = `LMS_MODE_SINGLE;
        ext_trig_sel = 0;
        dwell_sel = `LMS_DWELL_LIST;
        range_start = 5;
        range_stop = 6;
        tick(3);
        list_en = 1;
        tick(3);
        pulse(reset_cmd);
        tick(2);
        check(cur_index, 10'h5);
        index_wdata = 10'h6;
        pulse(index_wr);
        tick(2);
        check(cur_index, 10'h5);
        exp_q = '{10'h6, 10'h5, 10'h6};
        watch = 1;
        pulse(exec_cmd);
        tick(120);
        pulse(exec_cmd);
        drain(120);
        tick(20);
        watch = 0;
        list_en = 0;
        mode = `LMS_MODE_AUTO;
        dwell_sel = `LMS_DWELL_GLOBAL;
        global_dwell = 1;
        range_start = 0;
        range_stop = 7;
        rf_settled = 0;
        tick(3);
        list_en = 1;
        for (n = 0; n < 200 && overrun_off !== 1'b1; n++)
            tick(1);
        check(overrun_off, 1'b1);
        tick(2);
        check(list_active, 1'b0);
        final_report;
    end
endmodule // tb
`default_nettype wire
